// ---- core/tbio_timer_b.sv ----
// timer B register I/O control for channels 1 and 2: compare output and capture
// assumes synchronous pin inputs, one APB master, and a one-cycle channel 0 C event pulse
`timescale 1ns/1ns
`include "tbio_consts.svh"

module tbio_timer_b #(
	parameter int CNT_W = 16,
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ch0_c_event,
	input wire logic timer_pin_b_ch1_i,
	output logic timer_pin_b_ch1_o,
	output logic timer_pin_b_ch1_oe,
	input wire logic timer_pin_b_ch2_i,
	output logic timer_pin_b_ch2_o,
	output logic timer_pin_b_ch2_oe
);

	// ****************************************
	// elaboration checks
	// ****************************************
	if (CNT_W != 16) begin : g_bad_width
		$error("tbio_timer_b: counter width must be 16");
	end
	if (ADDR_W < 5) begin : g_bad_addr
		$error("tbio_timer_b: address too narrow for register map");
	end

	// ****************************************
	// helper functions
	// ****************************************
	function automatic logic next_level(input logic [1:0] act, input logic lvl);
		case (tbio_pkg::tbio_act_e'(act))
			tbio_pkg::TBIO_ACT_LOW: next_level = 1'b0;
			tbio_pkg::TBIO_ACT_HIGH: next_level = 1'b1;
			tbio_pkg::TBIO_ACT_TOGGLE: next_level = ~lvl;
			default: next_level = lvl;
		endcase
	endfunction : next_level

	function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
		case (tbio_pkg::tbio_edge_e'(sel))
			tbio_pkg::TBIO_EDGE_RISE: edge_hit = rise;
			tbio_pkg::TBIO_EDGE_FALL: edge_hit = fall;
			default: edge_hit = rise | fall;
		endcase
	endfunction : edge_hit

	function automatic logic [31:0] widen(input logic [15:0] v);
		widen = {16'h0000, v};
	endfunction : widen

	// ****************************************
	// state
	// ****************************************
	tbio_pkg::tbio_state_s r;
	tbio_pkg::tbio_state_s n;
	logic [1:0] pin_in;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] match;
	logic [1:0] cap;
	logic [1:0] wr_ioc;
	logic [1:0] wr_grb;
	logic [1:0] wr_cnt;
	logic setup;
	logic wr;
	logic [ADDR_W-1:0] waddr;

	assign pin_in = {timer_pin_b_ch2_i, timer_pin_b_ch1_i};

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		n = r;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		setup = psel & ~penable;
		wr = psel & penable & r.pready & pwrite;
		waddr = paddr;
		wr_ioc[0] = wr && (waddr == ADDR_W'(`TBIO_OFF_IOC_CH1));
		wr_ioc[1] = wr && (waddr == ADDR_W'(`TBIO_OFF_IOC_CH2));
		wr_cnt[0] = wr && (waddr == ADDR_W'(`TBIO_OFF_CNT_CH1));
		wr_cnt[1] = wr && (waddr == ADDR_W'(`TBIO_OFF_CNT_CH2));
		wr_grb[0] = wr && (waddr == ADDR_W'(`TBIO_OFF_GRB_CH1));
		wr_grb[1] = wr && (waddr == ADDR_W'(`TBIO_OFF_GRB_CH2));
		if (setup) begin
			n.pready = 1'b1;
			n.prdata = `TBIO_DATA_RST;
			case (paddr)
				ADDR_W'(`TBIO_OFF_IOC_CH1): n.prdata = {24'h00_0000, r.ioc[0]};
				ADDR_W'(`TBIO_OFF_IOC_CH2): n.prdata = {24'h00_0000, r.ioc[1]};
				ADDR_W'(`TBIO_OFF_CTRL): n.prdata = {30'h0000_0000, r.run};
				ADDR_W'(`TBIO_OFF_STATUS): n.prdata = {30'h0000_0000, r.flag};
				ADDR_W'(`TBIO_OFF_CNT_CH1): n.prdata = widen(r.cnt[0]);
				ADDR_W'(`TBIO_OFF_CNT_CH2): n.prdata = widen(r.cnt[1]);
				ADDR_W'(`TBIO_OFF_GRB_CH1): n.prdata = widen(r.grb[0]);
				ADDR_W'(`TBIO_OFF_GRB_CH2): n.prdata = widen(r.grb[1]);
				default: n.pslverr = 1'b1;
			endcase
		end
		if (wr && (waddr == ADDR_W'(`TBIO_OFF_CTRL))) begin
			n.run = pwdata[1:0];
		end
		n.prev = pin_in;
		for (int c = 0; c < 2; c++) begin
			rise[c] = pin_in[c] & ~r.prev[c];
			fall[c] = ~pin_in[c] & r.prev[c];
			// compare only while counting, so a stopped counter never fires
			match[c] = ~r.ioc[c][`TBIO_B_CAPTURE_BIT] & r.run[c] & (r.cnt[c] == r.grb[c]);
			if (!r.ioc[c][`TBIO_B_CAPTURE_BIT]) begin
				cap[c] = 1'b0;
			end else if (c == 0 && r.ioc[c][`TBIO_B_SOURCE_BIT]) begin
				cap[c] = ch0_c_event;
			end else begin
				// channel 2 falls here whatever bit6 holds
				cap[c] = edge_hit(r.ioc[c][5:4], rise[c], fall[c]);
			end
			if (wr_cnt[c]) begin
				n.cnt[c] = pwdata[15:0];
			end else if (r.run[c]) begin
				n.cnt[c] = r.cnt[c] + 16'h0001;
			end
			// capture beats a software write in the same cycle
			if (cap[c]) begin
				n.grb[c] = r.cnt[c];
			end else if (wr_grb[c]) begin
				n.grb[c] = pwdata[15:0];
			end
			if (match[c]) begin
				n.lvl[c] = next_level(r.ioc[c][5:4], r.lvl[c]);
			end
			if (wr_ioc[c]) begin
				n.ioc[c] = pwdata[7:0];
				if (!pwdata[`TBIO_B_CAPTURE_BIT]) begin
					n.oe[c] = |pwdata[5:4];
					n.lvl[c] = pwdata[`TBIO_B_LEVEL_BIT];
				end else begin
					n.oe[c] = 1'b0;
				end
			end
			// event beats clear
			n.flag[c] = (r.flag[c] & ~(wr && (waddr == ADDR_W'(`TBIO_OFF_STATUS)) && pwdata[c])) | cap[c] | match[c];
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r.ioc <= {`TBIO_IOC_RST, `TBIO_IOC_RST};
			r.run <= `TBIO_CTRL_RST;
			r.flag <= 2'h0;
			r.cnt <= {`TBIO_CNT_RST, `TBIO_CNT_RST};
			r.grb <= {`TBIO_GRB_RST, `TBIO_GRB_RST};
			r.lvl <= 2'h0;
			r.oe <= 2'h0;
			r.prev <= 2'h0;
			r.prdata <= `TBIO_DATA_RST;
			r.pready <= 1'b0;
			r.pslverr <= 1'b0;
		end else begin
			r <= n;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign timer_pin_b_ch1_o = r.lvl[0];
	assign timer_pin_b_ch1_oe = r.oe[0];
	assign timer_pin_b_ch2_o = r.lvl[1];
	assign timer_pin_b_ch2_oe = r.oe[1];

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_match1_code(logic [3:0] code);
		r.ioc[0][7:4] == code && match[0] && !wr_ioc[0];
	endsequence

	sequence s_pin_rise(int c);
		r.ioc[c][7] && rise[c];
	endsequence

	property p_compare_no_capture;
		!r.ioc[0][7] && !wr_grb[0] |=> r.grb[0] == $past(r.grb[0]);
	endproperty
	a_compare_no_capture: assert property (p_compare_no_capture) else $error("grb changed in compare mode");

	property p_low_on_match;
		s_match1_code(4'h1) |=> !timer_pin_b_ch1_o && timer_pin_b_ch1_oe;
	endproperty
	a_low_on_match: assert property (p_low_on_match) else $error("code 0001 match not low");

	property p_off_code;
		wr_ioc[1] && pwdata[7:4] == 4'h0 |=> !timer_pin_b_ch2_oe;
	endproperty
	a_off_code: assert property (p_off_code) else $error("code 0000 left pin driven");

	property p_high_on_match;
		s_match1_code(4'h2) |=> timer_pin_b_ch1_o;
	endproperty
	a_high_on_match: assert property (p_high_on_match) else $error("code 0010 match not high");

	property p_toggle;
		match[1] && r.ioc[1][5:4] == 2'b11 && !wr_ioc[1] |=> timer_pin_b_ch2_o != $past(timer_pin_b_ch2_o);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle missing on match");

	property p_init_high;
		wr_ioc[0] && pwdata[7:4] inside {4'h5, 4'h6, 4'h7} |=> timer_pin_b_ch1_o && timer_pin_b_ch1_oe;
	endproperty
	a_init_high: assert property (p_init_high) else $error("initial high missing");

	property p_rise_capture;
		s_pin_rise(0) && r.ioc[0][6:4] == 3'b000 |=> r.grb[0] == $past(r.cnt[0]);
	endproperty
	a_rise_capture: assert property (p_rise_capture) else $error("rising capture missing");

	property p_fall_capture;
		r.ioc[1][7:4] == 4'h9 && fall[1] |=> r.grb[1] == $past(r.cnt[1]) && r.flag[1];
	endproperty
	a_fall_capture: assert property (p_fall_capture) else $error("falling capture missing");

	property p_both_capture;
		r.ioc[0][7:5] == 3'b101 && (rise[0] || fall[0]) |=> r.grb[0] == $past(r.cnt[0]);
	endproperty
	a_both_capture: assert property (p_both_capture) else $error("both-edge capture missing");

	property p_event_source;
		r.ioc[0][7:6] == 2'b11 && !ch0_c_event && !wr_grb[0] |=> r.grb[0] == $past(r.grb[0]);
	endproperty
	a_event_source: assert property (p_event_source) else $error("pin captured in event mode");

	property p_event_capture;
		r.ioc[0][7:6] == 2'b11 && ch0_c_event |=> r.grb[0] == $past(r.cnt[0]);
	endproperty
	a_event_capture: assert property (p_event_capture) else $error("C event capture missing");

	property p_ch2_ignores_bit6;
		s_pin_rise(1) && r.ioc[1][5:4] == 2'b00 |=> r.grb[1] == $past(r.cnt[1]);
	endproperty
	a_ch2_ignores_bit6: assert property (p_ch2_ignores_bit6) else $error("channel 2 capture lost");

	// compare code with a live output written, then a cycle without match or rewrite
	sequence s_oc_write(int c);
		wr_ioc[c] && !pwdata[7] && pwdata[5:4] != 2'b00;
	endsequence

	sequence s_quiet(int c);
		!match[c] && !wr_ioc[c];
	endsequence

	property p_hold_initial;
		s_oc_write(1) ##1 s_quiet(1) |=> timer_pin_b_ch2_o == $past(timer_pin_b_ch2_o);
	endproperty
	a_hold_initial: assert property (p_hold_initial) else $error("initial level not held");

	property p_hold_initial_ch1;
		s_oc_write(0) ##1 s_quiet(0) |=> timer_pin_b_ch1_o == $past(timer_pin_b_ch1_o);
	endproperty
	a_hold_initial_ch1: assert property (p_hold_initial_ch1) else $error("ch1 initial level not held");

	property p_init_low;
		wr_ioc[1] && pwdata[7:4] inside {4'h1, 4'h2, 4'h3} |=> !timer_pin_b_ch2_o && timer_pin_b_ch2_oe;
	endproperty
	a_init_low: assert property (p_init_low) else $error("initial low missing");

	property p_off_code_ch1;
		wr_ioc[0] && pwdata[7:4] inside {4'h0, 4'h4} |=> !timer_pin_b_ch1_oe;
	endproperty
	a_off_code_ch1: assert property (p_off_code_ch1) else $error("disabled code left pin driven");

	property p_capture_oe_off;
		wr_ioc[0] && pwdata[7] |=> !timer_pin_b_ch1_oe;
	endproperty
	a_capture_oe_off: assert property (p_capture_oe_off) else $error("capture mode left pin driven");

	property p_low_on_match_ch2;
		match[1] && r.ioc[1][5:4] == 2'b01 && !wr_ioc[1] |=> !timer_pin_b_ch2_o;
	endproperty
	a_low_on_match_ch2: assert property (p_low_on_match_ch2) else $error("ch2 match not low");

	property p_high_on_match_ch2;
		match[1] && r.ioc[1][5:4] == 2'b10 && !wr_ioc[1] |=> timer_pin_b_ch2_o;
	endproperty
	a_high_on_match_ch2: assert property (p_high_on_match_ch2) else $error("ch2 match not high");

	property p_toggle_ch1;
		match[0] && r.ioc[0][5:4] == 2'b11 && !wr_ioc[0] |=> timer_pin_b_ch1_o != $past(timer_pin_b_ch1_o);
	endproperty
	a_toggle_ch1: assert property (p_toggle_ch1) else $error("ch1 toggle missing on match");

	property p_ch2_no_event;
		r.ioc[1][7] && !rise[1] && !fall[1] && !wr_grb[1] |=> r.grb[1] == $past(r.grb[1]);
	endproperty
	a_ch2_no_event: assert property (p_ch2_no_event) else $error("ch2 captured without pin edge");

	property p_both_capture_ch2;
		r.ioc[1][7] && r.ioc[1][5] && fall[1] |=> r.grb[1] == $past(r.cnt[1]);
	endproperty
	a_both_capture_ch2: assert property (p_both_capture_ch2) else $error("ch2 both-edge capture lost");

	property p_flag_on_capture;
		cap[0] |=> r.flag[0];
	endproperty
	a_flag_on_capture: assert property (p_flag_on_capture) else $error("capture flag missing");

	property p_unmapped_error;
		psel && !penable && (paddr[1:0] != 2'b00 || paddr > ADDR_W'(`TBIO_OFF_GRB_CH2))
			|=> pslverr && pready && prdata == `TBIO_DATA_RST;
	endproperty
	a_unmapped_error: assert property (p_unmapped_error) else $error("unmapped access not refused");

	property p_apb_answer;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

endmodule : tbio_timer_b

// ---- core/tbio_consts.svh ----
// register offsets, field positions, reset values for the timer B pin I/O block
// assumes inclusion by core files and the dv/ bench; defines hold no logic
`ifndef TBIO_CONSTS_SVH
`define TBIO_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TBIO_OFF_IOC_CH1 12'h000
`define TBIO_OFF_IOC_CH2 12'h004
`define TBIO_OFF_CTRL 12'h008
`define TBIO_OFF_STATUS 12'h00c
`define TBIO_OFF_CNT_CH1 12'h010
`define TBIO_OFF_CNT_CH2 12'h014
`define TBIO_OFF_GRB_CH1 12'h018
`define TBIO_OFF_GRB_CH2 12'h01c

// ****************************************
// field positions
// ****************************************
`define TBIO_B_MODE_MSB 7
`define TBIO_B_MODE_LSB 4
`define TBIO_B_CAPTURE_BIT 7
`define TBIO_B_LEVEL_BIT 6
`define TBIO_B_SOURCE_BIT 6

// ****************************************
// reset values
// ****************************************
`define TBIO_IOC_RST 8'h00
`define TBIO_CTRL_RST 2'h0
`define TBIO_CNT_RST 16'h0000
`define TBIO_GRB_RST 16'hffff
`define TBIO_DATA_RST 32'h0000_0000

`endif

// ---- core/tbio_pkg.sv ----
// types for the timer B pin I/O block
// assumes tbio_consts.svh holds the numbers
package tbio_pkg;

	typedef enum logic [1:0] {
		TBIO_ACT_HOLD = 2'b00,
		TBIO_ACT_LOW = 2'b01,
		TBIO_ACT_HIGH = 2'b10,
		TBIO_ACT_TOGGLE = 2'b11
	} tbio_act_e;

	typedef enum logic [1:0] {
		TBIO_EDGE_RISE = 2'b00,
		TBIO_EDGE_FALL = 2'b01,
		TBIO_EDGE_BOTH = 2'b10,
		TBIO_EDGE_BOTH_ALT = 2'b11
	} tbio_edge_e;

	typedef logic [15:0] tbio_count_t;

	typedef struct packed {
		logic [1:0][7:0] ioc;
		logic [1:0] run;
		logic [1:0] flag;
		logic [1:0][15:0] cnt;
		logic [1:0][15:0] grb;
		logic [1:0] lvl;
		logic [1:0] oe;
		logic [1:0] prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tbio_state_s;

endpackage : tbio_pkg

// ---- dv/tbio_pin_model.sv ----
// far-side model of one timer B channel pin
// assumes the bench sets the far-side level; the block wins while its enable is high
`timescale 1ns/1ns

module tbio_pin_model (
	input wire logic pin_o,
	input wire logic pin_oe,
	input wire logic drv_val,
	output logic pin_i
);
	// wire level: block drive when enabled, else far-side level
	assign pin_i = pin_oe ? pin_o : drv_val;
endmodule : tbio_pin_model

// ---- dv/tb_top.sv ----
// self-checking bench for the timer B pin I/O block: APB tasks, compare and capture tests
// assumes core/ on the include path and tbio_pin_model compiled first
`timescale 1ns/1ns
`include "tbio_consts.svh"

module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic ch0_c_event = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] pin_o;
	logic [1:0] pin_oe;
	logic [1:0] pin_i;
	logic [1:0] drv_val = 2'b11;
	logic [31:0] rd;
	logic err;
	int fail_count = 0;
	int compares = 0;

	always #10 pclk = ~pclk;

	tbio_timer_b u_tbio_timer_b (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ch0_c_event(ch0_c_event), .timer_pin_b_ch1_i(pin_i[0]),
		.timer_pin_b_ch1_o(pin_o[0]), .timer_pin_b_ch1_oe(pin_oe[0]), .timer_pin_b_ch2_i(pin_i[1]),
		.timer_pin_b_ch2_o(pin_o[1]), .timer_pin_b_ch2_oe(pin_oe[1]));
	tbio_pin_model u_tbio_pin_model_1 (.pin_o(pin_o[0]), .pin_oe(pin_oe[0]), .drv_val(drv_val[0]),
		.pin_i(pin_i[0]));
	tbio_pin_model u_tbio_pin_model_2 (.pin_o(pin_o[1]), .pin_oe(pin_oe[1]), .drv_val(drv_val[1]),
		.pin_i(pin_i[1]));

	// ****************************************
	// helpers
	// ****************************************
	task finish_test();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task chk1(input string name, input logic exp, input logic got);
		chk(name, {31'h0000_0000, exp}, {31'h0000_0000, got});
	endtask : chk1

	function logic [11:0] ad(input logic [11:0] base, input int c);
		return base + 12'(4 * c);
	endfunction : ad

	// apb transfer; waits for pready, only the watchdog ends a hang
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// ****************************************
	// compare output case
	// ****************************************
	task cmp_case(input int c, input logic [2:0] k);
		apb(1'b1, `TBIO_OFF_CTRL, 32'h0000_0000);
		apb(1'b1, ad(`TBIO_OFF_CNT_CH1, c), 32'h0000_0000);
		apb(1'b1, ad(`TBIO_OFF_GRB_CH1, c), 32'h0000_0003);
		apb(1'b1, ad(`TBIO_OFF_IOC_CH1, c), {24'h00_0000, 1'b0, k, 4'h0});
		#1;
		chk1("oe compare", |k[1:0], pin_oe[c]);
		if (|k[1:0]) begin
			chk1("pin initial", k[2], pin_i[c]);
		end
		apb(1'b1, `TBIO_OFF_CTRL, 32'(1 << c));
		repeat (8) @(posedge pclk);
		#1;
		if (|k[1:0]) begin
			chk1("pin after match", k[1] & (k[0] ? ~k[2] : 1'b1), pin_i[c]);
		end
	endtask : cmp_case

	// ****************************************
	// capture case
	// ****************************************
	task cap_case(input int c, input logic [3:0] k);
		logic ev;
		logic [31:0] e;
		ev = (c == 0) && k[2];
		apb(1'b1, `TBIO_OFF_CTRL, 32'h0000_0000);
		drv_val[c] <= 1'b0;
		apb(1'b1, ad(`TBIO_OFF_IOC_CH1, c), {24'h00_0000, k, 4'h0});
		apb(1'b1, ad(`TBIO_OFF_CNT_CH1, c), 32'h0000_1234);
		apb(1'b1, ad(`TBIO_OFF_GRB_CH1, c), 32'h0000_0000);
		chk1("oe capture", 1'b0, pin_oe[c]);
		apb(1'b1, `TBIO_OFF_STATUS, 32'h0000_0003);
		apb(1'b0, `TBIO_OFF_STATUS, 32'h0000_0000);
		chk1("status cleared", 1'b0, rd[c]);
		drv_val[c] <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b1, ad(`TBIO_OFF_CNT_CH1, c), 32'h0000_5678);
		drv_val[c] <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(1'b0, ad(`TBIO_OFF_GRB_CH1, c), 32'h0000_0000);
		e = ev ? 32'h0000_0000 : (k[1] | k[0]) ? 32'h0000_5678 : 32'h0000_1234;
		chk("grb pin capture", e, rd);
		apb(1'b1, ad(`TBIO_OFF_GRB_CH1, c), 32'h0000_0000);
		ch0_c_event <= 1'b1;
		@(posedge pclk);
		ch0_c_event <= 1'b0;
		repeat (2) @(posedge pclk);
		apb(1'b0, ad(`TBIO_OFF_GRB_CH1, c), 32'h0000_0000);
		chk("grb event capture", ev ? 32'h0000_5678 : 32'h0000_0000, rd);
		apb(1'b0, `TBIO_OFF_STATUS, 32'h0000_0000);
		chk1("status event", 1'b1, rd[c]);
		apb(1'b0, ad(`TBIO_OFF_IOC_CH1, c), 32'h0000_0000);
		chk("ioc readback", {24'h00_0000, k, 4'h0}, rd);
	endtask : cap_case

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `TBIO_OFF_IOC_CH1, 32'h0000_0000);
		chk("ioc reset", 32'h0000_0000, rd);
		apb(1'b0, `TBIO_OFF_GRB_CH2, 32'h0000_0000);
		chk("grb reset", 32'h0000_ffff, rd);
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk1("unmapped error", 1'b1, err);
		chk("unmapped data", 32'h0000_0000, rd);
		$display("test reset done");
		for (int c = 0; c < 2; c++) begin
			for (int k = 0; k < 8; k++) begin
				cmp_case(c, k[2:0]);
			end
		end
		$display("test compare done");
		for (int c = 0; c < 2; c++) begin
			for (int k = 8; k < 16; k++) begin
				cap_case(c, k[3:0]);
			end
		end
		$display("test capture done");
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		finish_test();
	end
endmodule : tb_top
